// [rtl/dprmc_pkg.sv]
// Package: register map, field positions and decode types for the PLL reference mode control
package dprmc_pkg;

    // ------------------------------------------------------------------
    // Register indices and byte addresses
    // ------------------------------------------------------------------
    localparam logic [7:0]  MODE_ONE_IDX    = 8'h2B;            // Printed index, mode one
    localparam logic [7:0]  MODE_TWO_IDX    = 8'h2C;            // Printed index, mode two
    localparam logic [11:0] MODE_ONE_ADDR   = {2'h0, MODE_ONE_IDX, 2'h0};
    localparam logic [11:0] MODE_TWO_ADDR   = {2'h0, MODE_TWO_IDX, 2'h0};
    localparam logic [15:0] MODE_ONE_RST    = 16'h0000;         // Reset value, mode one
    localparam logic [15:0] MODE_TWO_RST    = 16'h0000;         // Reset value, mode two

    // ------------------------------------------------------------------
    // Field positions, mode one
    // ------------------------------------------------------------------
    localparam int NET_REF_EN_BIT   = 15;                       // Network reference output enable
    localparam int B_DRIVE_BIT      = 14;                       // Second clock set drive
    localparam int A_DRIVE_BIT      = 13;                       // First clock set drive
    localparam int PREF_SEC_BIT     = 12;                       // Preferred reference select
    localparam int SEC_FREQ_LSB     = 10;                       // Secondary frequency field
    localparam int PRI_FREQ_LSB     = 8;                        // Primary frequency field
    localparam int SEC_SRC_LSB      = 4;                        // Secondary source select
    localparam int PRI_SRC_LSB      = 0;                        // Primary source select

    // ------------------------------------------------------------------
    // Field positions, mode two
    // ------------------------------------------------------------------
    localparam int HOLD_RST_BIT     = 11;                       // Holdover memory reset
    localparam int PHASE_RST_BIT    = 10;                       // Phase error reset
    localparam int FAIL_DET_LSB     = 8;                        // Failure detect field
    localparam logic [15:0] MODE_TWO_MASK = 16'h0FFB;           // Writable bits, mode two

    // ------------------------------------------------------------------
    // Decode types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        FREQ_8K     = 2'h0,
        FREQ_1544K  = 2'h1,
        FREQ_2048K  = 2'h2,
        FREQ_BUS8M  = 2'h3
    } dprmc_freq_t;

    typedef enum logic [3:0] {
        SRC_BUS_REF1 = 4'h0,
        SRC_BUS_REF2 = 4'h1,
        SRC_A_SET    = 4'h2,
        SRC_B_SET    = 4'h3,
        SRC_LOCAL0   = 4'h8,
        SRC_LOCAL1   = 4'h9,
        SRC_LOCAL2   = 4'hA,
        SRC_LOCAL3   = 4'hB,
        SRC_RESERVED = 4'hF
    } dprmc_src_t;

    typedef enum logic [1:0] {
        FDM_AUTO    = 2'h0,
        FDM_EXT     = 2'h1,
        FDM_FORCE_P = 2'h2,
        FDM_FORCE_S = 2'h3
    } dprmc_fdm_t;

    // Decoded reference choice for one path
    typedef struct packed {
        dprmc_src_t  src;       // Effective source
        dprmc_freq_t freq;      // Reference frequency
        logic        valid;     // Source code is not reserved
    } dprmc_ref_t;

    // Pad driver group for one pin
    typedef struct packed {
        logic o;                // Level driven
        logic oe;               // High while driven
    } dprmc_pad_t;

endpackage

// [rtl/dprmc_ref_decode.sv]
// Reference path decoder: source and frequency fields to effective reference
`timescale 1ns/1ps
module dprmc_ref_decode #(
    parameter logic IS_PRIMARY = 1'b1
) (
    // Raw fields
    input  wire logic [3:0]        srcSel,
    input  wire logic [1:0]        freqSel,
    // Decoded reference
    output dprmc_pkg::dprmc_ref_t  refOut
);
    import dprmc_pkg::*;

    // ------------------------------------------------------------------
    // Source code check
    // ------------------------------------------------------------------
    function automatic logic srcLegal(input logic [3:0] code);
        srcLegal = (code[3:2] == 2'h0) || (code[3:2] == 2'h2);
    endfunction

    // bus frequency forces the clock set
    always_comb begin
        refOut.freq = dprmc_freq_t'(freqSel);
        if (freqSel == FREQ_BUS8M) begin
            // Bus clock frequency overrides the select field
            refOut.src   = IS_PRIMARY ? SRC_A_SET : SRC_B_SET;
            refOut.valid = 1'b1;
        end else if (srcLegal(srcSel)) begin
            refOut.src   = dprmc_src_t'(srcSel);
            refOut.valid = 1'b1;
        end else begin
            // Reserved codes
            refOut.src   = SRC_RESERVED;
            refOut.valid = 1'b0;
        end
    end
endmodule

// [rtl/dprmc_top.sv]
// Top: APB register pair steering reference selection and pad enables
`timescale 1ns/1ps
module dprmc_top (
    // Clock and reset
    input  wire logic                 sys_clk,
    input  wire logic                 rst_b,
    input  wire logic                 clkEn,
    // APB slave
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [11:0]          paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    // Clock generator side
    input  wire logic                 netRefSrc,
    input  wire logic                 genClockA,
    input  wire logic                 genFrameA,
    input  wire logic                 genClockB,
    input  wire logic                 genFrameB,
    input  wire logic                 inHoldover,
    // Pads
    output dprmc_pkg::dprmc_pad_t     network_ref_output,
    output dprmc_pkg::dprmc_pad_t     bus_clock_a,
    output dprmc_pkg::dprmc_pad_t     frame_a,
    output dprmc_pkg::dprmc_pad_t     bus_clock_b,
    output dprmc_pkg::dprmc_pad_t     frame_b,
    // Decoded control to the PLL
    output dprmc_pkg::dprmc_ref_t     primaryRef,
    output dprmc_pkg::dprmc_ref_t     secondaryRef,
    output logic                      preferSecondary,
    output dprmc_pkg::dprmc_fdm_t     failure_detect_field,
    output logic                      holdover_memory_reset,
    output logic                      phase_error_reset,
    output logic                      forceFreerun,
    output logic                      alignFrameA,
    output logic                      alignFrameB
);
    import dprmc_pkg::*;

    // ------------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------------
    logic [15:0] pll_reference_mode_one_ff;     // Mode one register
    logic [15:0] pll_reference_mode_two_ff;     // Mode two register
    logic        holdReq_ff;                    // Holdover reset seen in holdover
    logic [31:0] prdata_ff;                     // Registered read data
    logic        pslverr_ff;                    // Registered error
    logic        accDone_ff;                    // Access phase answered
    logic        nxt_accDone;                   // Next answer state

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    function automatic logic [1:0] addrHit(input logic [11:0] a);
        addrHit = {a == MODE_TWO_ADDR, a == MODE_ONE_ADDR};
    endfunction

    logic [1:0] hit;        // One-hot register hit
    logic       setupOk;    // First access cycle seen
    assign hit     = addrHit(paddr);
    assign setupOk = psel && penable && !accDone_ff;

    // ------------------------------------------------------------------
    // APB handshake: one wait state, answered in second access cycle
    // ------------------------------------------------------------------
    assign nxt_accDone = setupOk;
    assign pready      = accDone_ff;
    assign prdata      = prdata_ff;
    assign pslverr     = pslverr_ff;

    // Access phase tracking
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            accDone_ff <= 1'b0;
        end else if (clkEn) begin
            accDone_ff <= nxt_accDone;
        end
    end

    // Read data and error capture
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            prdata_ff  <= 32'h0000_0000;
            pslverr_ff <= 1'b0;
        end else if (clkEn) begin
            if (setupOk) begin
                // Unmapped address answers with error, zero data
                pslverr_ff <= (hit == 2'h0);
                if (hit[0]) begin
                    prdata_ff <= {16'h0000, pll_reference_mode_one_ff};
                end else if (hit[1]) begin
                    prdata_ff <= {16'h0000, pll_reference_mode_two_ff};
                end else begin
                    prdata_ff <= 32'h0000_0000;
                end
            end else begin
                pslverr_ff <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Register writes, taken at the edge that completes the access
    // ------------------------------------------------------------------
    logic wrEdge;   // Write completes this edge
    assign wrEdge = psel && penable && accDone_ff && pwrite;

    // Mode one register
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            pll_reference_mode_one_ff <= MODE_ONE_RST;
        end else if (clkEn && wrEdge && hit[0]) begin
            pll_reference_mode_one_ff <= pwdata[15:0];
        end
    end

    // upper bits and bit two held at zero
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            pll_reference_mode_two_ff <= MODE_TWO_RST;
        end else if (clkEn && wrEdge && hit[1]) begin
            pll_reference_mode_two_ff <= pwdata[15:0] & MODE_TWO_MASK;
        end
    end

    // ------------------------------------------------------------------
    // Pad drivers
    // ------------------------------------------------------------------
    logic netEn;    // Network reference enable
    logic bDrive;   // B set drive
    logic aDrive;   // A set drive
    assign netEn  = pll_reference_mode_one_ff[NET_REF_EN_BIT];
    assign bDrive = pll_reference_mode_one_ff[B_DRIVE_BIT];
    assign aDrive = pll_reference_mode_one_ff[A_DRIVE_BIT];

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            network_ref_output <= '0;
        end else if (clkEn) begin
            network_ref_output.oe <= netEn;
            network_ref_output.o  <= netEn & netRefSrc;
        end
    end

    // B set pins driven or left as inputs
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            bus_clock_b <= '0;
            frame_b     <= '0;
        end else if (clkEn) begin
            bus_clock_b.oe <= bDrive;
            bus_clock_b.o  <= bDrive & genClockB;
            frame_b.oe     <= bDrive;
            frame_b.o      <= bDrive & genFrameB;
        end
    end

    // A set pins driven or left as inputs
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            bus_clock_a <= '0;
            frame_a     <= '0;
        end else if (clkEn) begin
            bus_clock_a.oe <= aDrive;
            bus_clock_a.o  <= aDrive & genClockA;
            frame_a.oe     <= aDrive;
            frame_a.o      <= aDrive & genFrameA;
        end
    end

    // ------------------------------------------------------------------
    // Reference decode
    // ------------------------------------------------------------------
    dprmc_pkg::dprmc_ref_t priDec;  // Primary decode
    dprmc_pkg::dprmc_ref_t secDec;  // Secondary decode

    dprmc_ref_decode #(
        .IS_PRIMARY (1'b1)
    ) u_pri (
        .srcSel  (pll_reference_mode_one_ff[PRI_SRC_LSB +: 4]),
        .freqSel (pll_reference_mode_one_ff[PRI_FREQ_LSB +: 2]),
        .refOut  (priDec)
    );

    dprmc_ref_decode #(
        .IS_PRIMARY (1'b0)
    ) u_sec (
        .srcSel  (pll_reference_mode_one_ff[SEC_SRC_LSB +: 4]),
        .freqSel (pll_reference_mode_one_ff[SEC_FREQ_LSB +: 2]),
        .refOut  (secDec)
    );

    // decoded choice and frame alignment registered
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            primaryRef      <= '0;
            secondaryRef    <= '0;
            preferSecondary <= 1'b0;
            alignFrameA     <= 1'b0;
            alignFrameB     <= 1'b0;
        end else if (clkEn) begin
            primaryRef      <= priDec;
            secondaryRef    <= secDec;
            preferSecondary <= pll_reference_mode_one_ff[PREF_SEC_BIT];
            alignFrameA     <= (priDec.src == SRC_A_SET) && !pll_reference_mode_one_ff[PREF_SEC_BIT];
            alignFrameB     <= (secDec.src == SRC_B_SET) && pll_reference_mode_one_ff[PREF_SEC_BIT];
        end
    end

    // ------------------------------------------------------------------
    // Holdover, phase error and failure detect controls
    // ------------------------------------------------------------------
    logic holdBit;  // Holdover memory reset bit
    assign holdBit = pll_reference_mode_two_ff[HOLD_RST_BIT];

    // holdover memory reset, freerun latch in holdover
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            holdover_memory_reset <= 1'b0;
            holdReq_ff            <= 1'b0;
        end else if (clkEn) begin
            holdover_memory_reset <= holdBit;
            if (holdBit && inHoldover) begin
                // Set only while in holdover; leaving holdover clears it even with the bit high
                holdReq_ff <= 1'b1;
            end else if (!inHoldover) begin
                holdReq_ff <= 1'b0;
            end
        end
    end
    assign forceFreerun = holdReq_ff;

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            phase_error_reset    <= 1'b0;
            failure_detect_field <= FDM_AUTO;
        end else if (clkEn) begin
            phase_error_reset    <= pll_reference_mode_two_ff[PHASE_RST_BIT];
            failure_detect_field <= dprmc_fdm_t'(pll_reference_mode_two_ff[FAIL_DET_LSB +: 2]);
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_net_pad_enable: assert property (@(posedge sys_clk) disable iff (!rst_b)
        clkEn |=> network_ref_output.oe == $past(netEn))
        else $error("network ref enable mismatch");

    a_b_set_drive: assert property (@(posedge sys_clk) disable iff (!rst_b)
        clkEn |=> (bus_clock_b.oe == $past(bDrive)) && (frame_b.oe == $past(bDrive)))
        else $error("B set drive mismatch");

    a_a_set_drive: assert property (@(posedge sys_clk) disable iff (!rst_b)
        clkEn |=> (bus_clock_a.oe == $past(aDrive)) && (frame_a.oe == $past(aDrive)))
        else $error("A set drive mismatch");

    a_freq_pass: assert property (@(posedge sys_clk) disable iff (!rst_b)
        clkEn |=> primaryRef.freq == $past(pll_reference_mode_one_ff[PRI_FREQ_LSB +: 2]))
        else $error("primary frequency mismatch");

    a_src_reserved: assert property (@(posedge sys_clk) disable iff (!rst_b)
        clkEn && pll_reference_mode_one_ff[PRI_FREQ_LSB +: 2] != 2'h3
        && pll_reference_mode_one_ff[2] |=> !primaryRef.valid)
        else $error("reserved source accepted");

    a_hold_freerun: assert property (@(posedge sys_clk) disable iff (!rst_b)
        clkEn && holdBit && inHoldover |=> forceFreerun)
        else $error("freerun not forced");

    a_phase_reset: assert property (@(posedge sys_clk) disable iff (!rst_b)
        clkEn |=> phase_error_reset == $past(pll_reference_mode_two_ff[PHASE_RST_BIT]))
        else $error("phase reset mismatch");

    a_upper_zero: assert property (@(posedge sys_clk) disable iff (!rst_b)
        pll_reference_mode_two_ff[15:12] == 4'h0)
        else $error("upper bits set");

    a_fdm_pass: assert property (@(posedge sys_clk) disable iff (!rst_b)
        clkEn |=> failure_detect_field == $past(pll_reference_mode_two_ff[FAIL_DET_LSB +: 2]))
        else $error("failure detect mismatch");

    a_bus_force_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        clkEn && pll_reference_mode_one_ff[PRI_FREQ_LSB +: 2] == 2'h3 |=> primaryRef.src == SRC_A_SET)
        else $error("A set not forced");

    a_apb_answer: assert property (@(posedge sys_clk) disable iff (!rst_b)
        clkEn && psel && penable && !pready |=> pready)
        else $error("APB answer late");

endmodule

// [dv/dprmc_backplane_model.sv]
// Backplane clock master model: resolves the shared A and B clock wires
`timescale 1ns/1ps
module dprmc_backplane_model (
    // Clock and reset
    input  wire logic               sys_clk,
    input  wire logic               rst_b,
    // Device pad groups and far-side drive request
    input  dprmc_pkg::dprmc_pad_t   padA,
    input  dprmc_pkg::dprmc_pad_t   padB,
    input  wire logic               extDrive,
    // Resolved wire levels
    output logic                    wireA,
    output logic                    wireB
);
    import dprmc_pkg::*;
    logic [3:0] extCnt_ff;    // Far-side master clock divider
    logic       lastA_ff;     // Last resolved A level
    logic       lastB_ff;     // Last resolved B level

    // -------------------------------------------------
    // Far-side master clock and wire memory
    // -------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            extCnt_ff <= 4'h0;
        end else begin
            extCnt_ff <= extCnt_ff + 4'h1;
        end
        lastA_ff <= wireA;
        lastB_ff <= wireB;
    end

    // Undriven wire follows the far-side master clock while extDrive is high, else shows inverse of last level
    assign wireA = padA.oe ? padA.o : (extDrive ? extCnt_ff[0] : ~lastA_ff);
    assign wireB = padB.oe ? padB.o : (extDrive ? extCnt_ff[1] : ~lastB_ff);
endmodule

// [dv/dprmc_top_tb.sv]
// Self-checking bench for the PLL reference mode control block
`timescale 1ns/1ps
module dprmc_top_tb;
    import dprmc_pkg::*;
    logic sys_clk, rst_b, psel, penable, pwrite, inHoldover, extDrive, clkEn;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic pready, pslverr, err, preferSecondary, holdover_memory_reset, phase_error_reset;
    logic forceFreerun, alignFrameA, alignFrameB, wireA, wireB;
    logic [7:0] genCnt;
    dprmc_pad_t network_ref_output, bus_clock_a, frame_a, bus_clock_b, frame_b;
    dprmc_ref_t primaryRef, secondaryRef;
    dprmc_fdm_t failure_detect_field;
    int bad_count, total_checks;

    dprmc_top u_dprmc_top (.sys_clk(sys_clk), .rst_b(rst_b), .clkEn(clkEn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .netRefSrc(genCnt[2]), .genClockA(genCnt[0]), .genFrameA(genCnt[7]), .genClockB(genCnt[1]),
        .genFrameB(genCnt[6]), .inHoldover(inHoldover), .network_ref_output(network_ref_output),
        .bus_clock_a(bus_clock_a), .frame_a(frame_a), .bus_clock_b(bus_clock_b), .frame_b(frame_b),
        .primaryRef(primaryRef), .secondaryRef(secondaryRef), .preferSecondary(preferSecondary),
        .failure_detect_field(failure_detect_field), .holdover_memory_reset(holdover_memory_reset),
        .phase_error_reset(phase_error_reset), .forceFreerun(forceFreerun), .alignFrameA(alignFrameA),
        .alignFrameB(alignFrameB));
    dprmc_backplane_model u_dprmc_backplane_model (.sys_clk(sys_clk), .rst_b(rst_b), .padA(bus_clock_a),
        .padB(bus_clock_b), .extDrive(extDrive), .wireA(wireA), .wireB(wireB));

    // -------------------------------------------------
    // Clock and generator activity
    // -------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) genCnt <= genCnt + 8'h01;

    // -------------------------------------------------
    // Compare, close and bus tasks
    // -------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("Checks %0d, mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // One APB transfer; waits for pready under a bound
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge sys_clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            bad_count++;
            $display("CHECK FAILED at %0t: no bus answer", $time);
            close_out();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    // Write then let the decoded outputs settle
    task automatic wr_settle(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        repeat (2) @(negedge sys_clk);
    endtask
    function automatic logic [31:0] exp_ref(input logic [3:0] c, input logic [1:0] f, input logic [3:0] bus);
        if (f == 2'h3) return {25'h0, bus, f, 1'b1};
        if (c[3:2] == 2'h0 || c[3:2] == 2'h2) return {25'h0, c, f, 1'b1};
        return {25'h0, 4'hF, f, 1'b0};
    endfunction

    // -------------------------------------------------
    // Main sequence
    // -------------------------------------------------
    initial begin
        logic [3:0] c;
        logic [1:0] f;
        logic [7:0] g;
        bad_count = 0; total_checks = 0; genCnt = 8'h00; rst_b = 1'b0; psel = 1'b0; penable = 1'b0;
        pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0; inHoldover = 1'b0; extDrive = 1'b1; clkEn = 1'b1;
        repeat (5) @(posedge sys_clk);
        rst_b <= 1'b1;
        apb(1'b0, MODE_ONE_ADDR, 32'h0); chk(rd, 32'h0, "mode one reset");
        apb(1'b0, MODE_TWO_ADDR, 32'h0); chk(rd, 32'h0, "mode two reset");
        // Pad drive enables, one bit at a time
        for (int b = 13; b <= 15; b++) begin
            wr_settle(MODE_ONE_ADDR, 32'h1 << b);
            // Generator value sampled at the last rising edge
            g = genCnt - 8'h01;
            chk(network_ref_output.oe, b == 15, "net ref oe");
            chk(network_ref_output.o, (b == 15) & g[2], "net ref level");
            chk({bus_clock_b.oe, frame_b.oe}, (b == 14) ? 2'h3 : 2'h0, "B set oe");
            chk({bus_clock_a.oe, frame_a.oe}, (b == 13) ? 2'h3 : 2'h0, "A set oe");
            chk(wireA, (b == 13) ? g[0] : u_dprmc_backplane_model.extCnt_ff[0], "A wire");
            chk(wireB, (b == 14) ? g[1] : u_dprmc_backplane_model.extCnt_ff[1], "B wire");
            chk({bus_clock_b.o, frame_b.o}, (b == 14) ? {g[1], g[6]} : 2'h0, "B set levels");
            chk({bus_clock_a.o, frame_a.o}, (b == 13) ? {g[0], g[7]} : 2'h0, "A set levels");
            if (b != 13) chk(bus_clock_a.o, 1'b0, "A level idle");
        end
        // Every source code against every frequency code
        for (int i = 0; i < 64; i++) begin
            c = i[3:0];
            f = i[5:4];
            wr_settle(MODE_ONE_ADDR, {16'h0, 4'h0, 2'h0 - f, f, ~c, c});
            chk(primaryRef, exp_ref(c, f, SRC_A_SET), "primary ref");
            chk(secondaryRef, exp_ref(~c, 2'h0 - f, SRC_B_SET), "secondary ref");
            // Primary on the A set, by bus rate or by source code
            chk(alignFrameA, f == 2'h3 || c == 4'h2, "align A");
        end
        apb(1'b0, MODE_ONE_ADDR, 32'h0); chk(rd, 32'h0000_070F, "mode one readback");
        wr_settle(MODE_ONE_ADDR, 32'h0000_1F00);
        chk({preferSecondary, alignFrameA, alignFrameB}, 3'h5, "secondary preferred");
        // Failure detect modes with reset bits, upper bits kept zero
        for (int m = 0; m < 4; m++) begin
            wr_settle(MODE_TWO_ADDR, {20'h0, m[0], m[1], m[1:0], 8'h00});
            chk(failure_detect_field, m[1:0], "fail detect");
            chk({holdover_memory_reset, phase_error_reset}, {m[0], m[1]}, "reset bits");
            apb(1'b0, MODE_TWO_ADDR, 32'h0); chk(rd, {20'h0, m[0], m[1], m[1:0], 8'h00}, "mode two rd");
        end
        wr_settle(MODE_TWO_ADDR, 32'hFFFF_FFFF);
        apb(1'b0, MODE_TWO_ADDR, 32'h0); chk(rd, 32'h0000_0FFB, "mode two reserved");
        // Holdover memory reset while in holdover
        wr_settle(MODE_TWO_ADDR, 32'h0000_0400);
        @(posedge sys_clk);
        inHoldover <= 1'b1;
        repeat (3) @(negedge sys_clk);
        chk(forceFreerun, 1'b0, "no freerun");
        wr_settle(MODE_TWO_ADDR, 32'h0000_0C00);
        chk(forceFreerun, 1'b1, "freerun set");
        wr_settle(MODE_TWO_ADDR, 32'h0000_0400);
        chk(forceFreerun, 1'b1, "freerun held after pulse");
        // Clock enable low freezes the freerun latch
        @(posedge sys_clk);
        clkEn <= 1'b0;
        inHoldover <= 1'b0;
        repeat (3) @(negedge sys_clk);
        chk(forceFreerun, 1'b1, "freerun frozen by clock enable");
        @(posedge sys_clk);
        clkEn <= 1'b1;
        repeat (3) @(negedge sys_clk);
        chk(forceFreerun, 1'b0, "freerun cleared");
        // Unmapped address refused, mode one register unchanged
        apb(1'b1, 12'h0B4, 32'h0000_FFFF); chk(err, 1'b1, "unmapped write");
        apb(1'b0, 12'h0B4, 32'h0); chk({err, rd}, {1'b1, 32'h0}, "unmapped read");
        apb(1'b0, MODE_ONE_ADDR, 32'h0); chk({err, rd}, {1'b0, 32'h0000_1F00}, "mode one kept");
        close_out();
    end
endmodule
